// >>> design/nscop_cyc_engine.sv
// One asynchronous bus cycle: command, address, data out or data in
`timescale 1ns/1ps
`default_nettype none
`include "nscop_defines.svh"
module nscop_cyc_engine
  import nscop_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  nscop_cyc_if.eng cyc,
  input wire logic [7:0] i_io_sync,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic [7:0] o_io,
  output logic o_io_oe_n
);
  typedef enum logic [1:0] {
    NSCOP_E_IDLE, NSCOP_E_LOW, NSCOP_E_HIGH, NSCOP_E_GAP
  } nscop_eng_e;
  nscop_eng_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] rdata_q;
  logic wr_q;
  assign cyc.done = (st_q == NSCOP_E_GAP) && (cnt_q == 4'h0);
  assign cyc.rdata = rdata_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= NSCOP_E_IDLE;
      cnt_q <= 4'h0;
      rdata_q <= 8'h00;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_io <= 8'h00;
      o_io_oe_n <= 1'b1;
      wr_q <= 1'b0;
    end else if (i_ce) begin
      case (st_q)
        NSCOP_E_IDLE: begin
          if (cyc.req) begin
            wr_q <= (cyc.kind != NSCOP_CYC_DOUT);
            o_cle <= (cyc.kind == NSCOP_CYC_CMD);
            o_ale <= (cyc.kind == NSCOP_CYC_ADDR);
            o_io <= cyc.wdata;
            o_io_oe_n <= (cyc.kind == NSCOP_CYC_DOUT);
            o_we_n <= (cyc.kind == NSCOP_CYC_DOUT);
            o_re_n <= (cyc.kind != NSCOP_CYC_DOUT);
            // Read strobe held low until the byte has passed both sync flops
            cnt_q <= (cyc.kind == NSCOP_CYC_DOUT) ?
              4'(`NSCOP_STROBE_CYC + `NSCOP_SYNC_CYC) : 4'(`NSCOP_STROBE_CYC);
            st_q <= NSCOP_E_LOW;
          end
        end
        NSCOP_E_LOW: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            // Sample read data just before the rising read strobe
            if (!wr_q) begin
              rdata_q <= i_io_sync;
            end
            o_we_n <= 1'b1;
            o_re_n <= 1'b1;
            st_q <= NSCOP_E_HIGH;
          end
        end
        NSCOP_E_HIGH: begin
          o_cle <= 1'b0;
          o_ale <= 1'b0;
          o_io_oe_n <= 1'b1;
          cnt_q <= cyc.gap;
          st_q <= NSCOP_E_GAP;
        end
        default: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            st_q <= NSCOP_E_IDLE;
          end
        end
      endcase
    end
  end

  sequence s_go_cmd_sent;
    $rose(o_we_n) && o_cle && (o_io == `NSCOP_CMD_RAND_READ_GO);
  endsequence
  property p_cmd_out_wait;
    @(posedge i_clk) disable iff (!i_nrst)
      s_go_cmd_sent |-> o_re_n [*6];
  endproperty
  a_cmd_out_wait: assert property (p_cmd_out_wait) // RQ15
    else $error("read strobe fell too soon after go command");
  property p_cmd_addr_excl;
    @(posedge i_clk) disable iff (!i_nrst)
      !(o_cle && o_ale);
  endproperty
  a_cmd_addr_excl: assert property (p_cmd_addr_excl) // RQ14
    else $error("command and address latch both high");
  // Byte must still stand on the bus when the write strobe rises
  property p_write_held;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_we_n) |-> $stable(o_io) && !o_io_oe_n;
  endproperty
  a_write_held: assert property (p_write_held) // RQ18
    else $error("bus byte not held at rising write strobe");
endmodule : nscop_cyc_engine
`default_nettype wire

// >>> design/nscop_cyc_if.sv
// Carrier between sequencer and bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface nscop_cyc_if;
  import nscop_pkg::*;
  logic req;
  nscop_cyc_e kind;
  logic [7:0] wdata;
  logic [3:0] gap;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output kind, output wdata, output gap,
    input done, input rdata);
  modport eng (input req, input kind, input wdata, input gap,
    output done, output rdata);
endinterface : nscop_cyc_if
`default_nettype wire

// >>> design/nscop_defines.svh
// Constants for the NAND status and column operation host controller
`ifndef NSCOP_DEFINES_SVH
`define NSCOP_DEFINES_SVH
`define NSCOP_CMD_READ_STATUS 8'h70
`define NSCOP_CMD_READ_MODE 8'h00
`define NSCOP_CMD_RAND_READ 8'h05
`define NSCOP_CMD_RAND_READ_GO 8'hE0
`define NSCOP_CMD_RAND_INPUT 8'h85
`define NSCOP_STAT_WP_N 7
`define NSCOP_STAT_RDY 6
`define NSCOP_STAT_ARRAY_RDY 5
`define NSCOP_STAT_REWRITE 3
`define NSCOP_STAT_PREV_FAIL 1
`define NSCOP_STAT_FAIL 0
`define NSCOP_SYNC_CYC 2
`define NSCOP_CLK_MHZ 20
`define NSCOP_PERIOD_NS 50
`define NSCOP_T_STROBE_NS 50
`define NSCOP_T_CMD_OUT_NS 120
`define NSCOP_T_ADDR_IN_NS 100
`define NSCOP_STROBE_CYC ((`NSCOP_T_STROBE_NS + `NSCOP_PERIOD_NS - 1) / `NSCOP_PERIOD_NS)
`define NSCOP_CMD_OUT_CYC ((`NSCOP_T_CMD_OUT_NS + `NSCOP_PERIOD_NS - 1) / `NSCOP_PERIOD_NS)
`define NSCOP_ADDR_IN_CYC ((`NSCOP_T_ADDR_IN_NS + `NSCOP_PERIOD_NS - 1) / `NSCOP_PERIOD_NS)
`define NSCOP_OP_STATUS 3'h0
`define NSCOP_OP_READ_MODE 3'h1
`define NSCOP_OP_RAND_READ 3'h2
`define NSCOP_OP_RAND_INPUT 3'h3
`define NSCOP_OP_INT_INPUT 3'h4
`define NSCOP_OP_DATA_RD 3'h5
`define NSCOP_OP_DATA_WR 3'h6
`endif

// >>> design/nscop_host.sv
// Host controller issuing status and column address operations
`timescale 1ns/1ps
`default_nettype none
`include "nscop_defines.svh"
// Summary of operation
// [RQ1] Each die keeps its own status byte; host reads the selected one
// [RQ2] After 70h every data read returns the status byte
// [RQ3] With read strobe held low, status changes show without toggling
// [RQ4] Host issues 00h after status polling before reading page data
// [RQ5] Host reads status after corrected read time for error outcome
// [RQ6] Bit 6 ready, busy pin follows it
// [RQ7] Bit 5 array ready, low during programming
// [RQ8] Bit 3 set when rewrite is advised after read
// [RQ9] Bit 0 set on program, erase or uncorrectable read failure
// [RQ10] Status read works on the last die even while busy
// [RQ11] Single die target: status read usable after any command
// [RQ12] Column commands reach any byte of the cache register
// [RQ13] Random read accepted when ready, or cache read with die ready
// [RQ14] Random read is 05h, two column cycles, E0h, then data output
// [RQ15] Host waits command-to-output time after E0h before reading
// [RQ16] Random input is 85h plus two column cycles, then data input
// [RQ17] Host waits address-to-input time after second column cycle
// [RQ18] Data input optional; written from given column until next command
// [RQ19] 85h allowed inside program sequences before final command
// [RQ20] Internal input: 85h, two column, three row cycles, then wait
// [RQ21] Host keeps die and plane bits unchanged when redirecting
// [RQ22] Modify move: load cache with 00h-35h, then 85h and new data
// [RQ23] Bit 7 low when write protected, high otherwise
// [RQ24] In status mode data reads return only the status byte
module nscop_host
  import nscop_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_op_valid,
  output logic o_op_ready,
  input wire logic [2:0] i_op,
  input wire logic [15:0] i_col,
  input wire logic [23:0] i_row,
  input wire logic [7:0] i_wdata,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_rdata_is_status,
  output logic [7:0] o_status,
  output logic o_ready_bit,
  output logic o_array_ready_bit,
  output logic o_fail_bit,
  output logic o_rewrite_bit,
  output logic o_wp_clear,
  output logic o_busy_pin,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic [7:0] o_io,
  output logic o_io_oe_n,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n
);
  nscop_cyc_if cyc ();
  logic [7:0] io_s1_q;
  logic [7:0] io_s2_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic [2:0] op_q;
  logic [15:0] col_q;
  logic [23:0] row_q;
  logic [7:0] wdata_q;
  logic [2:0] step_q;
  logic act_q;
  logic req_q;
  nscop_cyc_e kind_q;
  logic [7:0] byte_q;
  logic [3:0] gap_q;
  nscop_mode_e mode_q;

  function automatic logic [2:0] last_step(input logic [2:0] op);
    case (op)
      `NSCOP_OP_STATUS: last_step = 3'd1;
      `NSCOP_OP_READ_MODE: last_step = 3'd0;
      `NSCOP_OP_RAND_READ: last_step = 3'd3;
      `NSCOP_OP_RAND_INPUT: last_step = 3'd2;
      `NSCOP_OP_INT_INPUT: last_step = 3'd5;
      default: last_step = 3'd0;
    endcase
  endfunction : last_step

  nscop_cyc_engine u_eng (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .cyc(cyc),
    .i_io_sync(io_s2_q),
    .o_cle(o_cle),
    .o_ale(o_ale),
    .o_we_n(o_we_n),
    .o_re_n(o_re_n),
    .o_io(o_io),
    .o_io_oe_n(o_io_oe_n)
  );

  // Pins from the device cross two flops before use
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      // Ready pin idles high; resetting to ready avoids a false busy
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else if (i_ce) begin
      io_s1_q <= i_io;
      io_s2_q <= io_s1_q;
      rb_s1_q <= i_rb_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  assign o_op_ready = !act_q;
  assign o_ce_n = 1'b0;
  assign cyc.req = req_q;
  assign cyc.kind = kind_q;
  assign cyc.wdata = byte_q;
  assign cyc.gap = gap_q;
  assign o_ready_bit = o_status[`NSCOP_STAT_RDY]; // RQ6
  assign o_array_ready_bit = o_status[`NSCOP_STAT_ARRAY_RDY]; // RQ7
  assign o_rewrite_bit = o_status[`NSCOP_STAT_REWRITE]; // RQ8
  assign o_fail_bit = o_status[`NSCOP_STAT_FAIL]; // RQ9
  assign o_wp_clear = o_status[`NSCOP_STAT_WP_N]; // RQ23
  assign o_busy_pin = !rb_s2_q; // RQ6

  // Next cycle of the current operation, by step index
  always_comb begin
    kind_q = NSCOP_CYC_ADDR;
    byte_q = 8'h00;
    gap_q = 4'h0;
    case (step_q)
      3'd0: begin
        kind_q = NSCOP_CYC_CMD;
        case (op_q)
          `NSCOP_OP_STATUS: byte_q = `NSCOP_CMD_READ_STATUS; // RQ10
          `NSCOP_OP_READ_MODE: byte_q = `NSCOP_CMD_READ_MODE; // RQ4
          `NSCOP_OP_RAND_READ: byte_q = `NSCOP_CMD_RAND_READ; // RQ14
          `NSCOP_OP_DATA_RD: kind_q = NSCOP_CYC_DOUT;
          `NSCOP_OP_DATA_WR: begin
            kind_q = NSCOP_CYC_DIN; // RQ18 RQ22
            byte_q = wdata_q;
          end
          default: byte_q = `NSCOP_CMD_RAND_INPUT; // RQ16 RQ19 RQ20
        endcase
        if (op_q == `NSCOP_OP_STATUS) begin
          gap_q = 4'(`NSCOP_CMD_OUT_CYC);
        end
      end
      3'd1: begin
        if (op_q == `NSCOP_OP_STATUS) begin
          kind_q = NSCOP_CYC_DOUT; // RQ2
        end else begin
          byte_q = col_q[7:0]; // RQ12
        end
      end
      3'd2: begin
        byte_q = col_q[15:8];
        if (op_q == `NSCOP_OP_RAND_INPUT) begin
          gap_q = 4'(`NSCOP_ADDR_IN_CYC); // RQ17
        end
      end
      3'd3: begin
        if (op_q == `NSCOP_OP_RAND_READ) begin
          kind_q = NSCOP_CYC_CMD;
          byte_q = `NSCOP_CMD_RAND_READ_GO;
          gap_q = 4'(`NSCOP_CMD_OUT_CYC); // RQ15
        end else begin
          byte_q = row_q[7:0];
        end
      end
      3'd4: byte_q = row_q[15:8];
      default: begin
        byte_q = row_q[23:16];
        gap_q = 4'(`NSCOP_ADDR_IN_CYC); // RQ20
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      act_q <= 1'b0;
      req_q <= 1'b0;
      step_q <= 3'd0;
      op_q <= 3'd0;
      col_q <= 16'h0000;
      row_q <= 24'h00_0000;
      wdata_q <= 8'h00;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (!act_q && i_op_valid) begin
        act_q <= 1'b1;
        req_q <= 1'b1;
        step_q <= 3'd0;
        op_q <= i_op;
        col_q <= i_col;
        row_q <= i_row; // RQ21
        wdata_q <= i_wdata;
      end else if (act_q && req_q) begin
        req_q <= 1'b0;
      end else if (act_q && cyc.done) begin
        // Data ops are one cycle long
        if (step_q == last_step(op_q) || op_q >= `NSCOP_OP_DATA_RD) begin
          act_q <= 1'b0;
          o_done <= 1'b1;
        end else begin
          step_q <= step_q + 3'd1;
          req_q <= 1'b1;
        end
      end
    end
  end

  // Output mode tracks the last command; status mode marks reads as status
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= NSCOP_MODE_NONE;
      o_rdata <= 8'h00;
      o_rdata_is_status <= 1'b0;
      o_status <= 8'h00;
    end else if (i_ce) begin
      if (act_q && cyc.done && step_q == 3'd0) begin
        case (op_q)
          `NSCOP_OP_STATUS: mode_q <= NSCOP_MODE_STATUS;
          `NSCOP_OP_READ_MODE: mode_q <= NSCOP_MODE_DOUT;
          `NSCOP_OP_RAND_INPUT: mode_q <= NSCOP_MODE_DIN;
          `NSCOP_OP_INT_INPUT: mode_q <= NSCOP_MODE_DIN;
          default: mode_q <= mode_q;
        endcase
      end
      if (act_q && cyc.done && op_q == `NSCOP_OP_RAND_READ) begin
        mode_q <= NSCOP_MODE_DOUT;
      end
      if (act_q && cyc.done && kind_q == NSCOP_CYC_DOUT) begin
        o_rdata <= cyc.rdata; // RQ24
        o_rdata_is_status <= (mode_q == NSCOP_MODE_STATUS);
        if (mode_q == NSCOP_MODE_STATUS) begin
          o_status <= cyc.rdata; // RQ2 RQ5
        end
      end
    end
  end

  sequence s_col_hi_sent;
    $rose(o_we_n) && o_ale && (op_q == `NSCOP_OP_RAND_INPUT) &&
      (step_q == 3'd2);
  endsequence
  property p_addr_in_wait;
    @(posedge i_clk) disable iff (!i_nrst)
      s_col_hi_sent |-> o_we_n [*5];
  endproperty
  a_addr_in_wait: assert property (p_addr_in_wait) // RQ17
    else $error("data strobe too soon after column address");
  sequence s_status_cmd_done;
    act_q && cyc.done && (op_q == `NSCOP_OP_STATUS) && (step_q == 3'd0);
  endsequence
  property p_status_then_read;
    @(posedge i_clk) disable iff (!i_nrst)
      s_status_cmd_done |-> ##2 !o_re_n;
  endproperty
  a_status_then_read: assert property (p_status_then_read) // RQ2
    else $error("status command not followed by a read cycle");
  property p_read_marks_status;
    @(posedge i_clk) disable iff (!i_nrst)
      (act_q && cyc.done && (kind_q == NSCOP_CYC_DOUT) &&
        (mode_q == NSCOP_MODE_STATUS)) |=> o_rdata_is_status &&
        (o_status == o_rdata);
  endproperty
  a_read_marks_status: assert property (p_read_marks_status) // RQ24
    else $error("read in status mode not marked as status");
endmodule : nscop_host
`default_nettype wire

// >>> design/nscop_pkg.sv
// Types for the NAND status and column operation host controller
package nscop_pkg;
  typedef enum logic [2:0] {
    NSCOP_CYC_CMD, NSCOP_CYC_ADDR, NSCOP_CYC_DOUT, NSCOP_CYC_DIN
  } nscop_cyc_e;
  typedef enum logic [1:0] {
    NSCOP_MODE_NONE, NSCOP_MODE_STATUS, NSCOP_MODE_DOUT, NSCOP_MODE_DIN
  } nscop_mode_e;
endpackage : nscop_pkg

// >>> tb/nscop_host_tb_top.sv
// Self-checking bench for the status and column operation host
`timescale 1ns/1ps
`default_nettype none
`include "nscop_defines.svh"
module nscop_host_tb_top;
  import nscop_pkg::*;
  typedef struct {logic [2:0] op; logic [15:0] col; logic [7:0] wd, ex;
    logic chk;} nscop_row_s;
  logic i_clk, i_nrst, i_op_valid, o_op_ready, o_done, o_rdata_is_status;
  logic o_ready_bit, o_array_ready_bit, o_fail_bit, o_rewrite_bit;
  logic o_wp_clear, o_busy_pin, o_ce_n, o_cle, o_ale, o_we_n, o_re_n;
  logic o_io_oe_n, wp_n, rdy, arr_rdy, rew, fail;
  logic [2:0] i_op;
  logic [15:0] i_col;
  logic [7:0] i_wdata, o_rdata, o_status, o_io, dev_io, bus, stat_byte, rd;
  logic [23:0] row_q;
  int viol, errors, total_checks;
  nscop_row_s rows [12];
  assign stat_byte = {wp_n, rdy, arr_rdy, 1'b0, rew, 2'b00, fail};
  assign bus = o_io_oe_n ? dev_io : o_io;
  nscop_host i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_op_valid(i_op_valid), .o_op_ready(o_op_ready), .i_op(i_op),
    .i_col(i_col), .i_row(24'h12_3456), .i_wdata(i_wdata), .o_done(o_done),
    .o_rdata(o_rdata), .o_rdata_is_status(o_rdata_is_status),
    .o_status(o_status), .o_ready_bit(o_ready_bit),
    .o_array_ready_bit(o_array_ready_bit), .o_fail_bit(o_fail_bit),
    .o_rewrite_bit(o_rewrite_bit), .o_wp_clear(o_wp_clear),
    .o_busy_pin(o_busy_pin), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
    .o_we_n(o_we_n), .o_re_n(o_re_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n),
    .i_io(bus), .i_rb_n(rdy));
  nscop_nand_model i_dev (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
    .i_we_n(o_we_n), .i_re_n(o_re_n), .i_io(bus), .i_status_byte(stat_byte),
    .o_io(dev_io),
    .o_row_q(row_q), .o_viol(viol));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk_byte(input string nm, input logic [7:0] ex, got);
    total_checks++;
    if (got !== ex) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string nm, input logic ex, got);
    chk_byte(nm, {7'd0, ex}, {7'd0, got});
  endtask : chk_bit
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Request held until ready is sampled; result taken in the done cycle
  task automatic run_op(input logic [2:0] op, input logic [15:0] col,
    input logic [7:0] wd, output logic [7:0] r);
    int n;
    n = 0;
    i_op = op;
    i_col = col;
    i_wdata = wd;
    i_op_valid = 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_op_ready !== 1'b1 && n < 400);
    #1 i_op_valid = 1'b0;
    while (o_done !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    r = o_rdata;
    if (n >= 400) errors++;
  endtask : run_op
  initial begin
    #300us;
    errors++;
    tally_and_finish();
  end
  initial begin
    {i_nrst, i_op_valid, i_op, i_col, i_wdata} = '0;
    {wp_n, rdy, arr_rdy, rew, fail} = 5'b11100;
    errors = 0;
    total_checks = 0;
    rows = '{
      '{`NSCOP_OP_RAND_INPUT, 16'h0010, 8'h00, 8'h00, 0},
      '{`NSCOP_OP_DATA_WR, 16'h0000, 8'hA5, 8'h00, 0},
      '{`NSCOP_OP_DATA_WR, 16'h0000, 8'h3C, 8'h00, 0},
      '{`NSCOP_OP_INT_INPUT, 16'h0020, 8'h00, 8'h00, 0},
      '{`NSCOP_OP_DATA_WR, 16'h0000, 8'h77, 8'h00, 0},
      '{`NSCOP_OP_RAND_READ, 16'h0010, 8'h00, 8'h00, 0},
      '{`NSCOP_OP_DATA_RD, 16'h0000, 8'h00, 8'hA5, 1},
      '{`NSCOP_OP_DATA_RD, 16'h0000, 8'h00, 8'h3C, 1},
      '{`NSCOP_OP_STATUS, 16'h0000, 8'h00, 8'hE0, 1},
      '{`NSCOP_OP_DATA_RD, 16'h0000, 8'h00, 8'hE0, 1},
      '{`NSCOP_OP_READ_MODE, 16'h0000, 8'h00, 8'h00, 0},
      '{`NSCOP_OP_DATA_RD, 16'h0000, 8'h00, 8'h00, 1}};
    repeat (16) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    chk_bit("done_after_reset", 1'b0, o_done);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].col, rows[i].wd, rd);
      if (rows[i].chk) chk_byte("row_rdata", rows[i].ex, rd);
    end
    chk_byte("dest_row", 8'h56, row_q[7:0]);
    chk_byte("dest_row_hi", 8'h12, row_q[23:16]);
    chk_bit("array_ready_set", 1'b1, o_array_ready_bit);
    chk_bit("wp_set", 1'b1, o_wp_clear);
    chk_bit("busy_pin_idle", 1'b0, o_busy_pin);
    chk_bit("rdata_not_status", 1'b0, o_rdata_is_status);
    chk_bit("ce_n", 1'b0, o_ce_n);
    {wp_n, rdy, arr_rdy, rew, fail} = 5'b00001;
    run_op(`NSCOP_OP_STATUS, 16'h0000, 8'h00, rd);
    chk_byte("busy_status", 8'h01, rd);
    chk_bit("ready_bit", 1'b0, o_ready_bit);
    chk_bit("busy_pin", 1'b1, o_busy_pin);
    chk_bit("fail_bit", 1'b1, o_fail_bit);
    chk_bit("wp_clear", 1'b0, o_wp_clear);
    chk_bit("rdata_is_status", 1'b1, o_rdata_is_status);
    {wp_n, rdy, arr_rdy, rew, fail} = 5'b11010;
    run_op(`NSCOP_OP_STATUS, 16'h0000, 8'h00, rd);
    chk_byte("cache_status", 8'hC8, rd);
    chk_bit("array_ready", 1'b0, o_array_ready_bit);
    chk_bit("rewrite_bit", 1'b1, o_rewrite_bit);
    chk_bit("fail_clear", 1'b0, o_fail_bit);
    chk_byte("wait_violations", 8'h00, 8'(viol));
    // Second reset in mid-run: state clears, then a status read works again
    @(posedge i_clk);
    #1 i_nrst = 1'b0;
    @(posedge i_clk);
    #1 i_nrst = 1'b1;
    chk_byte("status_after_reset", 8'h00, o_status);
    chk_bit("ready_after_reset", 1'b1, o_op_ready);
    run_op(`NSCOP_OP_STATUS, 16'h0000, 8'h00, rd);
    chk_byte("status_restart", 8'hC8, rd);
    tally_and_finish();
  end
endmodule : nscop_host_tb_top
`default_nettype wire

// >>> tb/nscop_nand_model.sv
// Behavioural die: status byte, cache register and bus cycle decode
`timescale 1ns/1ps
`default_nettype none
module nscop_nand_model (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic [7:0] i_io,
  input wire logic [7:0] i_status_byte,
  output logic [7:0] o_io,
  output logic [23:0] o_row_q,
  output int o_viol
);
  logic [7:0] mem [256];
  logic [1:0] mode;
  logic [7:0] cmd;
  logic [15:0] col;
  logic [7:0] last;
  int na;
  realtime t_e0, t_adr;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mode = 2'd0;
    col = 16'h0000;
    last = 8'h00;
    o_viol = 0;
    o_row_q = 24'h00_0000;
  end
  always @(posedge i_we_n) if (!i_ce_n) begin
    if (i_cle) begin
      cmd = i_io;
      na = 0;
      if (i_io == 8'h70) mode = 2'd1;
      else if (i_io == 8'h00) mode = 2'd2;
      else if (i_io == 8'hE0) begin
        mode = 2'd2;
        t_e0 = $realtime;
      end
    end else if (i_ale) begin
      if (na == 0) col[7:0] = i_io;
      else if (na == 1) col[15:8] = i_io;
      else o_row_q[8*(na-2) +: 8] = i_io;
      na++;
      if (cmd == 8'h85 && na >= 2) begin
        mode = 2'd3;
        t_adr = $realtime;
      end
    end else if (mode == 2'd3) begin
      if ($realtime - t_adr < 100) o_viol++;
      mem[col[7:0]] = i_io;
      col++;
    end
  end
  // Host must hold off its first read strobe after E0h
  always @(negedge i_re_n)
    if (!i_ce_n && mode == 2'd2 && $realtime - t_e0 < 120) o_viol++;
  always @(posedge i_re_n) if (!i_ce_n) begin
    last = (mode == 2'd1) ? i_status_byte : mem[col[7:0]];
    if (mode == 2'd2) col++;
  end
  // Live status in status mode while strobe low; released bus shows inverted last byte
  assign o_io = (!i_ce_n && !i_re_n) ?
    (mode == 2'd1 ? i_status_byte : mem[col[7:0]]) : ~last;
endmodule : nscop_nand_model
`default_nettype wire
